// ==== hdl/adcr_host.sv ====
// Host end: starts conversions and clocks the whole chain out
`timescale 1ns/100ps
module adcr_host
  import adcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  adcr_link_if.host link,
  input wire logic startReq,
  input wire logic busyMode,
  output logic idle,
  output logic [CHAIN_BITS-1:0] dataOut,
  output logic dataValid
);

  // Sequencer state
  adcr_host_state_type state_q;
  adcr_host_state_type state_d;
  // Phase and wait counter
  logic [CONV_W-1:0] waitCnt_q;
  logic [CONV_W-1:0] waitCnt_d;
  // Bits sampled so far
  logic [BIT_W-1:0] bitCnt_q;
  logic [BIT_W-1:0] bitCnt_d;
  // Serial clock and start drivers
  logic sck_q;
  logic sck_d;
  logic startPin_q;
  logic startPin_d;
  // Busy bit mode of the running frame
  logic mode_q;
  logic mode_d;
  // Bits gathered, first received in the top bit
  logic [CHAIN_BITS-1:0] shift_q;
  logic [CHAIN_BITS-1:0] shift_d;
  // Chain output synchroniser stages
  logic sdoA_q;
  logic sdoB_q;

  // Half period of the serial clock elapsed
  wire halfDone = (waitCnt_q == CONV_W'(SCK_HALF_CYCLES - 1));
  // Conversion surely finished
  wire waitDone = (waitCnt_q == CONV_W'(HOST_WAIT - 1));
  // Last bit of the chain sampled
  wire lastBit = (bitCnt_q == BIT_W'(CHAIN_BITS));
  // Counter advanced by one
  wire [CONV_W-1:0] waitInc = waitCnt_q + CONV_W'(1);

  assign link.conversionStart = startPin_q;
  assign link.serialClock = sck_q;
  assign link.serialIn = 1'b0;

  // Two-flop synchroniser on the chain output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdoA_q <= 1'b0;
      sdoB_q <= 1'b0;
    end else begin
      sdoA_q <= link.serialOut;
      sdoB_q <= sdoA_q;
    end
  end

  // Sequencer next values
  always_comb begin
    state_d = state_q;
    waitCnt_d = waitInc;
    bitCnt_d = bitCnt_q;
    sck_d = sck_q;
    startPin_d = startPin_q;
    mode_d = mode_q;
    shift_d = shift_q;
    case (state_q)
      HST_IDLE: begin
        waitCnt_d = CONV_W'(0);
        if (startReq) begin
          mode_d = busyMode;
          sck_d = busyMode;
          state_d = HST_ARM;
        end
      end
      HST_ARM: begin
        // Clock level settles before start rises
        if (halfDone) begin
          startPin_d = 1'b1;
          waitCnt_d = CONV_W'(0);
          state_d = HST_WAIT;
        end
      end
      HST_WAIT: begin
        if (mode_q && sdoB_q) begin
          sck_d = 1'b0;
          waitCnt_d = CONV_W'(0);
          state_d = HST_LEAD;
        end else if (!mode_q && waitDone) begin
          sck_d = 1'b1;
          waitCnt_d = CONV_W'(0);
          state_d = HST_HIGH;
        end
      end
      HST_LEAD: begin
        if (halfDone) begin
          sck_d = 1'b1;
          waitCnt_d = CONV_W'(0);
          state_d = HST_HIGH;
        end
      end
      HST_HIGH: begin
        if (halfDone) begin
          shift_d = {shift_q[CHAIN_BITS-2:0], sdoB_q};
          bitCnt_d = bitCnt_q + BIT_W'(1);
          sck_d = 1'b0;
          waitCnt_d = CONV_W'(0);
          state_d = HST_LOW;
        end
      end
      HST_LOW: begin
        if (halfDone) begin
          waitCnt_d = CONV_W'(0);
          if (lastBit) begin
            state_d = HST_FINISH;
          end else begin
            sck_d = 1'b1;
            state_d = HST_HIGH;
          end
        end
      end
      HST_FINISH: begin
        // Frame closes by dropping start
        startPin_d = 1'b0;
        bitCnt_d = BIT_W'(0);
        waitCnt_d = CONV_W'(0);
        state_d = HST_IDLE;
      end
      default: begin
        state_d = HST_IDLE;
        startPin_d = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= HST_IDLE;
      waitCnt_q <= CONV_W'(0);
      bitCnt_q <= BIT_W'(0);
      sck_q <= 1'b0;
      startPin_q <= 1'b0;
      mode_q <= 1'b0;
      shift_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      waitCnt_q <= waitCnt_d;
      bitCnt_q <= bitCnt_d;
      sck_q <= sck_d;
      startPin_q <= startPin_d;
      mode_q <= mode_d;
      shift_q <= shift_d;
    end
  end

  // User side outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle <= 1'b1;
      dataOut <= 32'h0000_0000;
      dataValid <= 1'b0;
    end else begin
      idle <= (state_d == HST_IDLE);
      dataValid <= (state_q == HST_FINISH);
      if (state_q == HST_FINISH) begin
        dataOut <= shift_q;
      end
    end
  end

endmodule

// ==== hdl/adcr_pkg.sv ====
// Shared constants and types for the chained converter readout
package adcr_pkg;
  // Result width of one converter
  localparam int WORD_BITS = 16;
  // Number of converters chained behind one host
  localparam int CHAIN_LEN = 2;
  // Total result bits read from the whole chain
  localparam int CHAIN_BITS = WORD_BITS * CHAIN_LEN;
  // System clock period
  localparam int CLK_PERIOD_NS = 5;
  // Conversion time of the internal clock
  localparam int CONV_TIME_NS = 1000;
  // Conversion length in clk cycles, rounded up
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the conversion counter
  localparam int CONV_W = 8;
  // Extra host wait for pin synchronisers
  localparam int SYNC_MARGIN = 8;
  // Host wait before reading without the busy bit
  localparam int HOST_WAIT = CONV_CYCLES + SYNC_MARGIN;
  // Serial clock half period made by the host
  localparam int SCK_HALF_NS = 20;
  // Half period in clk cycles, rounded up
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Unused; the host phase counter is CONV_W bits wide
  localparam int HALF_W = 4;
  // Falling edge count at which the device counter rests
  localparam int EDGE_SAT = WORD_BITS + 1;
  // Width of the device edge counter
  localparam int EDGE_W = 5;
  // Width of the host bit counter
  localparam int BIT_W = 7;
  // Device sequencer states
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_CONV = 3'b010,
    DEV_READY = 3'b100
  } adcr_dev_state_type;
  // Host sequencer states
  typedef enum logic [6:0] {
    HST_IDLE = 7'b000_0001,
    HST_ARM = 7'b000_0010,
    HST_WAIT = 7'b000_0100,
    HST_LEAD = 7'b000_1000,
    HST_HIGH = 7'b001_0000,
    HST_LOW = 7'b010_0000,
    HST_FINISH = 7'b100_0000
  } adcr_host_state_type;
endpackage

// ==== hdl/adcr_link_if.sv ====
// Serial link between the host and one converter position in the chain
`timescale 1ns/100ps
interface adcr_link_if;
  // Shared conversion start line
  logic conversionStart;
  // Shared serial clock line
  logic serialClock;
  // Data into the converter's chain input
  logic serialIn;
  // Data out of the converter's chain output
  logic serialOut;
  // Host end: drives start, clock and the head input
  modport host (
    output conversionStart,
    output serialClock,
    output serialIn,
    input serialOut
  );
  // Converter end
  modport device (
    input conversionStart,
    input serialClock,
    input serialIn,
    output serialOut
  );
endinterface

// ==== hdl/adcr_device.sv ====
// Converter end: conversion sequencer and chained serial output
`timescale 1ns/100ps

// Summary of operation
// - Host shares one start and one clock line
// - Output low when input and start low
// - Start rise with input low selects chain
// - Host holds start high through readout
// - Conversion runs on own clock only
// - Clock level at start selects busy bit
// - Without busy bit, MSB appears at completion
// - Falling clock shifts input in, next out
// - Host gives sixteen falls per converter
// - With busy bit, output goes high
// - Host gives sixteen per converter plus one
// - Upstream busy bit is never passed on
// - Host samples on either clock edge; adcr_host samples only just before each clock fall
// - Input tied to start still selects chain
module adcr_device
  import adcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  adcr_link_if.device link,
  input wire logic [WORD_BITS-1:0] sampleIn,
  output logic converting
);

  // ---- Internal clock domain ----

  // Raw pins: bit 0 start, bit 1 chain input, bit 2 serial clock
  wire [2:0] pinRaw;
  // First synchroniser stage, read only by the second
  logic [2:0] syncA_q;
  // Second synchroniser stage
  logic [2:0] syncB_q;
  // Start level one cycle ago
  logic startLast_q;
  // Chain input level one cycle ago
  logic sdiLast_q;
  // Sequencer state
  adcr_dev_state_type state_q;
  adcr_dev_state_type state_d;
  // Conversion cycle counter
  logic [CONV_W-1:0] convCnt_q;
  logic [CONV_W-1:0] convCnt_d;
  // Sampled input held as the result
  logic [WORD_BITS-1:0] result_q;
  // Chained operation selected at the last start
  logic chain_q;
  // Busy bit selected at the last start
  logic busy_q;
  // Result ready for readout
  logic done_q;

  assign pinRaw = {link.serialClock, link.serialIn, link.conversionStart};

  // Synchronised views of the pins
  wire startSync = syncB_q[0];
  wire sdiSync = syncB_q[1];
  wire sckSync = syncB_q[2];
  // Start rising edge seen in this domain
  wire startRise = startSync & ~startLast_q;
  // Conversion counter at its last cycle
  wire convEnd = (convCnt_q == CONV_W'(CONV_CYCLES - 1));
  // Sequencer accepts a new start
  wire takeStart = (state_q == DEV_IDLE) & startRise;
  // Ready state is entered next cycle
  wire doneNext = (state_d == DEV_READY);

  // Two-flop synchronisers for the three pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
    end else begin
      syncA_q <= pinRaw;
      syncB_q <= syncA_q;
    end
  end

  // Previous levels for edge and strap detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      startLast_q <= 1'b0;
      sdiLast_q <= 1'b0;
    end else begin
      startLast_q <= startSync;
      sdiLast_q <= sdiSync;
    end
  end

  // Next state and conversion count
  always_comb begin
    state_d = state_q;
    convCnt_d = convCnt_q;
    case (state_q)
      DEV_IDLE: begin
        // Start edge launches a conversion
        if (startRise) begin
          state_d = DEV_CONV;
          convCnt_d = CONV_W'(0);
        end
      end
      DEV_CONV: begin
        // internal clock only
        // Counts regardless of start or serial clock activity
        if (convEnd) begin
          state_d = DEV_READY;
        end else begin
          convCnt_d = convCnt_q + CONV_W'(1);
        end
      end
      DEV_READY: begin
        // Frame ends when the host drops start
        if (!startSync) begin
          state_d = DEV_IDLE;
        end
      end
      default: begin
        state_d = DEV_IDLE;
        convCnt_d = CONV_W'(0);
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DEV_IDLE;
      convCnt_q <= CONV_W'(0);
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      convCnt_q <= convCnt_d;
      done_q <= doneNext;
    end
  end

  // chain select on start
  // Mode bits and the sample are caught at the start edge.
  // tied input reads low
  // The input level just before the edge is used, so an input
  // wired to start still reads low and selects the chain.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chain_q <= 1'b0;
      busy_q <= 1'b0;
      result_q <= 16'h0000;
    end else if (takeStart) begin
      chain_q <= ~sdiLast_q;
      busy_q <= sckSync;
      result_q <= sampleIn;
    end
  end

  // Conversion in progress flag for the user side
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      converting <= 1'b0;
    end else begin
      converting <= (state_d == DEV_CONV);
    end
  end

  // ---- Serial clock domain ----

  // Readout frame alive: start high, result ready, chain mode.
  // Dropping any of them clears the shift logic at once, so no
  // serial clock edge is needed after the frame ends.
  wire frameRstN = reset_n & link.conversionStart & done_q & chain_q;
  // Falling edges counted in this frame, resting at the limit
  logic [EDGE_W-1:0] edgeCnt_q;
  // Bits taken from the chain input
  logic [WORD_BITS-1:0] cap_q;
  // First fall after a busy bit only drops the busy bit
  wire busyEdge = busy_q & (edgeCnt_q == EDGE_W'(0));
  // upstream busy bit skipped
  // The input is not taken on the busy fall, so the upstream
  // busy bit never enters this converter's shift path.
  wire capEn = ~busyEdge;
  // Counter has reached its resting value
  wire edgeSat = (edgeCnt_q == EDGE_W'(EDGE_SAT));

  always_ff @(negedge link.serialClock or negedge frameRstN) begin
    if (!frameRstN) begin
      edgeCnt_q <= EDGE_W'(0);
    end else if (!edgeSat) begin
      edgeCnt_q <= edgeCnt_q + EDGE_W'(1);
    end
  end

  always_ff @(negedge link.serialClock or negedge frameRstN) begin
    if (!frameRstN) begin
      cap_q <= 16'h0000;
    end else if (capEn) begin
      cap_q <= {cap_q[WORD_BITS-2:0], link.serialIn};
    end
  end

  // ---- Output selection ----

  // Own result bits shifted out so far
  wire [EDGE_W-1:0] shiftCnt = busy_q ? (edgeCnt_q - EDGE_W'(1)) : edgeCnt_q;
  // Still inside the own result word
  wire ownWord = (shiftCnt < EDGE_W'(WORD_BITS));
  // Index of the own result bit now on the output
  wire [3:0] bitIdx = 4'(WORD_BITS - 1) - shiftCnt[3:0];
  // Own result bit, MSB first
  wire ownBit = result_q[bitIdx];
  // Upstream bit delayed by one word
  wire passBit = cap_q[WORD_BITS-1];
  // Readout frame active
  wire frameOn = link.conversionStart & done_q & chain_q;
  // Output value during a frame
  logic frameBit;

  // Frame output: busy bit, own word, then upstream data
  always_comb begin
    frameBit = passBit;
    if (busyEdge) begin
      frameBit = 1'b1;
    end else if (ownWord) begin
      frameBit = ownBit;
    end
  end

  // low with start low
  // Outside a frame the output rests low, which covers the case of
  // start and chain input both low.
  assign link.serialOut = frameOn ? frameBit : 1'b0;

endmodule

// ==== testbench/adcr_link_asserts.sv ====
// Checker for the link at the last converter of the chain
`timescale 1ns/100ps
module adcr_link_asserts
  import adcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conversionStart,
  input wire logic serialClock,
  input wire logic serialIn,
  input wire logic serialOut
);
  // Window for the busy flag after the start rise
  localparam int CONV_MIN = 195;
  localparam int CONV_MAX = 215;
  // Serial clock falls in this frame
  logic [6:0] fallCount_q;
  // Cycles since the last fall, saturating
  logic [3:0] sinceFall_q;
  // Cycles since the start rise, saturating
  logic [8:0] convCount_q;
  // Busy selection taken at the start rise
  logic busySel_q;
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Count falls inside a frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fallCount_q <= '0;
    end else if ($rose(conversionStart)) begin
      fallCount_q <= '0;
    end else if ($fell(serialClock) && conversionStart) begin
      fallCount_q <= fallCount_q + 7'h1;
    end
  end

  // Age of the last fall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sinceFall_q <= 4'hF;
    end else if ($fell(serialClock)) begin
      sinceFall_q <= 4'h0;
    end else if (sinceFall_q != 4'hF) begin
      sinceFall_q <= sinceFall_q + 4'h1;
    end
  end

  // Age of the frame and busy selection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      convCount_q <= 9'h1FF;
      busySel_q <= 1'h0;
    end else if ($rose(conversionStart)) begin
      convCount_q <= 9'h0;
      busySel_q <= serialClock;
    end else if (convCount_q != 9'h1FF) begin
      convCount_q <= convCount_q + 9'h1;
    end
  end

  // Start rise with the clock high
  sequence busyStart;
    $rose(conversionStart) && serialClock;
  endsequence
  // Flag shows at the end of conversion
  sequence flagAtEnd;
    ##[CONV_MIN:CONV_MAX] serialOut;
  endsequence

  AST_OUT_LOW: assert property (!conversionStart && !serialIn |-> !serialOut)
    else $error("output high while start and input low");
  AST_CHAIN_QUIET: assert property ($rose(conversionStart) |-> !serialOut [*8])
    else $error("output active right after start");
  AST_FRAME_FALLS: assert property ($fell(conversionStart) |->
    fallCount_q == CHAIN_BITS + int'(busySel_q))
    else $error("wrong count of clock falls in frame");
  AST_CONV_OWN_CLOCK: assert property ($rose(serialOut) && busySel_q &&
    fallCount_q == 7'h0 |-> convCount_q >= 9'(CONV_CYCLES))
    else $error("conversion ended too early");
  AST_BUSY_FLAG: assert property (busyStart |-> flagAtEnd)
    else $error("busy flag missing at end of conversion");
  AST_SHIFT_WINDOW: assert property ($changed(serialOut) && conversionStart &&
    fallCount_q != 7'h0 |-> $fell(serialClock) || sinceFall_q == 4'h0)
    else $error("output moved away from a clock fall");
  AST_HOLD_HIGH: assert property ($rose(serialClock) && conversionStart &&
    fallCount_q != 7'h0 |=> $stable(serialOut) [*3])
    else $error("output moved during clock high");
  AST_TAIL_ZERO: assert property ($fell(conversionStart) |-> !$past(serialOut))
    else $error("output not zero after last bit");
endmodule

// ==== testbench/tb.sv ====
// Bench: host and two chained converters with result checks
`timescale 1ns/100ps
module tb;
  import adcr_pkg::*;
  // Clocks, reset and host user side
  logic clk, devClk, reset_n, startReq, busyMode, idle, dataValid, convA, convB, convC;
  // Converter samples
  logic [WORD_BITS-1:0] sampleA, sampleB;
  // Received chain data
  logic [CHAIN_BITS-1:0] dataOut;
  int mismatches, n_compared;
  // Host link and one link per converter
  adcr_link_if hostLink();
  adcr_link_if linkA();
  adcr_link_if linkB();
  assign linkA.conversionStart = hostLink.conversionStart;
  assign linkB.conversionStart = hostLink.conversionStart;
  assign linkA.serialClock = hostLink.serialClock;
  assign linkB.serialClock = hostLink.serialClock;
  assign linkA.serialIn = hostLink.serialIn;
  assign linkB.serialIn = linkA.serialOut;
  assign hostLink.serialOut = linkB.serialOut;
  // strapped converter, chain input tied to start
  adcr_link_if linkC();
  assign linkC.conversionStart = hostLink.conversionStart;
  assign linkC.serialClock = hostLink.serialClock;
  assign linkC.serialIn = linkC.conversionStart;
  // Strapped converter bits, one per serial clock rise in a frame
  logic [CHAIN_BITS-1:0] strapBits;

  adcr_host i_adcr_host (.clk(clk), .reset_n(reset_n), .link(hostLink), .startReq(startReq),
    .busyMode(busyMode), .idle(idle), .dataOut(dataOut), .dataValid(dataValid));
  adcr_device i_adcr_device_a (.clk(devClk), .reset_n(reset_n), .link(linkA),
    .sampleIn(sampleA), .converting(convA));
  adcr_device i_adcr_device_b (.clk(devClk), .reset_n(reset_n), .link(linkB),
    .sampleIn(sampleB), .converting(convB));
  adcr_device i_adcr_device_c (.clk(devClk), .reset_n(reset_n), .link(linkC),
    .sampleIn(sampleB), .converting(convC));
  adcr_link_asserts i_adcr_link_asserts (.clk(clk), .reset_n(reset_n),
    .conversionStart(linkB.conversionStart), .serialClock(linkB.serialClock),
    .serialIn(linkB.serialIn), .serialOut(linkB.serialOut));

  // Host clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // Converter clock, shifted phase
  initial begin
    devClk = 1'h0;
    #1.7;
    forever #2.5 devClk = ~devClk;
  end

  // Collect the strapped output while the host clocks a frame
  always @(posedge hostLink.serialClock) begin
    if (hostLink.conversionStart) begin
      strapBits <= {strapBits[CHAIN_BITS-2:0], linkC.serialOut};
    end
  end

  // Compare and count
  task automatic check(input logic [CHAIN_BITS-1:0] seen, input logic [CHAIN_BITS-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One frame; poke changes samples and retries start mid-frame
  task automatic frame(input logic busy, input logic [15:0] a, input logic [15:0] b,
    input logic poke);
    int n;
    for (n = 0; n < 50 && idle !== 1'h1; n++) @(posedge clk);
    if (n == 50) begin
      mismatches++;
      return;
    end
    sampleA <= a;
    sampleB <= b;
    startReq <= 1'h1;
    busyMode <= busy;
    @(posedge clk);
    startReq <= 1'h0;
    if (poke) begin
      repeat (20) @(posedge clk);
      sampleA <= ~a;
      sampleB <= ~b;
      startReq <= 1'h1;
      busyMode <= ~busy;
      @(posedge clk);
      startReq <= 1'h0;
    end
    for (n = 0; n < 2000 && dataValid !== 1'h1; n++) @(posedge clk);
    if (n == 2000) begin
      mismatches++;
      return;
    end
    check(dataOut, {b, a});
    check(strapBits, {b, 16'hFFFF});
    @(posedge clk);
    check(hostLink.serialOut, 1'h0);
    check({convA, convB, convC}, 3'h0);
  endtask

  // Main sequence
  initial begin
    reset_n = 1'h0;
    startReq = 1'h0;
    busyMode = 1'h0;
    sampleA = '0;
    sampleB = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    check(hostLink.serialOut, 1'h0);
    check(idle, 1'h1);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk);
    // Plain, busy, refused start, back to back
    frame(1'h0, 16'h8000, 16'h0001, 1'h0);
    frame(1'h1, 16'hFFFF, 16'h0000, 1'h0);
    frame(1'h1, 16'h0001, 16'h8000, 1'h1);
    frame(1'h0, 16'h5A5A, 16'hA5A5, 1'h1);
    conclude();
  end
endmodule
